//--- verilog/pgc_pkg.sv
// constants, encodings and types of the general command set
// assumes an 8-bit command/data port and a serial engine reporting
// one completed transaction per pulse
package pgc_pkg;

  localparam int          BYTE_W        = 8;
  localparam int          WORD_W        = 16;
  localparam int          EP_COUNT      = 16;
  localparam int          EP_W          = 4;
  localparam int          PID_NIB       = 4;
  localparam int          SCRATCH_W     = 13;
  localparam int          FRAME_W       = 11;

  // command codes
  localparam logic [7:0]  CMD_STATUS_LO = 8'hA0;
  localparam logic [7:0]  CMD_STATUS_HI = 8'hAF;
  localparam logic [7:0]  CMD_UNLOCK    = 8'hB0;
  localparam logic [7:0]  CMD_SCR_WR    = 8'hB2;
  localparam logic [7:0]  CMD_SCR_RD    = 8'hB3;
  localparam logic [7:0]  CMD_FRAME     = 8'hB4;
  localparam logic [7:0]  CMD_IDENT     = 8'hB5;
  localparam logic [15:0] UNLOCK_KEY    = 16'hAA37;

  // status byte layout
  localparam int          ST_STATUS_OVERRUN_FLAG     = 7;
  localparam int          ST_TOGGLE     = 6;
  localparam int          ST_ERR_MSB    = 4;
  localparam int          ST_ERR_LSB    = 1;
  localparam int          ST_OK         = 0;
  localparam logic [7:0]  STATUS_RESET  = 8'h00;

  // error field values
  localparam logic [3:0]  ERR_NONE      = 4'h0;
  localparam logic [3:0]  ERR_PID_CHECK = 4'h1;
  localparam logic [3:0]  ERR_PID_UNDEF = 4'h2;
  localparam logic [3:0]  ERR_UNEXPECT  = 4'h3;
  localparam logic [3:0]  ERR_TOKEN_CRC = 4'h4;
  localparam logic [3:0]  ERR_DATA_CRC  = 4'h5;
  localparam logic [3:0]  ERR_TIMEOUT   = 4'h6;
  localparam logic [3:0]  ERR_BABBLE    = 4'h7;
  localparam logic [3:0]  ERR_EOP       = 4'h8;
  localparam logic [3:0]  ERR_NAK       = 4'h9;
  localparam logic [3:0]  ERR_STALL     = 4'hA;
  localparam logic [3:0]  ERR_OVERFLOW  = 4'hB;
  localparam logic [3:0]  ERR_ISO_EMPTY = 4'hC;
  localparam logic [3:0]  ERR_STUFF     = 4'hD;
  localparam logic [3:0]  ERR_SYNC      = 4'hE;
  localparam logic [3:0]  ERR_TOGGLE    = 4'hF;

  // fault vector positions reported by the serial engine
  localparam int          FAULT_W       = 13;
  localparam int          FLT_UNEXPECT  = 0;
  localparam int          FLT_TOKEN_CRC = 1;
  localparam int          FLT_DATA_CRC  = 2;
  localparam int          FLT_TIMEOUT   = 3;
  localparam int          FLT_BABBLE    = 4;
  localparam int          FLT_EOP       = 5;
  localparam int          FLT_NAK       = 6;
  localparam int          FLT_STALL     = 7;
  localparam int          FLT_OVERFLOW  = 8;
  localparam int          FLT_ISO_EMPTY = 9;
  localparam int          FLT_STUFF     = 10;
  localparam int          FLT_SYNC      = 11;
  localparam int          FLT_TOGGLE    = 12;

  // pid nibbles and endpoint limits
  localparam logic [3:0]  PID_OUT       = 4'h1;
  localparam logic [3:0]  PID_IN        = 4'h9;
  localparam logic [3:0]  PID_SOF       = 4'h5;
  localparam logic [3:0]  PID_SETUP     = 4'hD;
  localparam logic [3:0]  PID_DATA0     = 4'h3;
  localparam logic [3:0]  PID_DATA1     = 4'hB;
  localparam logic [3:0]  PID_ACK       = 4'h2;
  localparam logic [3:0]  PID_NAK       = 4'hA;
  localparam logic [3:0]  PID_STALL     = 4'hE;
  localparam logic [3:0]  PID_PRE       = 4'hC;
  localparam logic [3:0]  EP_CTRL_LAST  = 4'h1;

  typedef enum logic [2:0] {
    PGC_IDLE, PGC_STATUS, PGC_UNLOCK, PGC_SCR_WR, PGC_SCR_RD, PGC_FRAME, PGC_IDENT
  } pgc_cmd_type;

endpackage : pgc_pkg

//--- verilog/pgc_general_commands.sv
// general command interpreter: endpoint status, unlock, scratch,
// frame number and identity over the 8-bit command/data port
// assumes strobes are one-cycle pulses synchronous to ref_clk
//
// Operation
// - status command A0..AF returns one status byte of the chosen endpoint
// - each completed transaction replaces the endpoint's recorded status, except bit 6, which changes only on a good packet
// - bit 7 set when a new event lands before the old status was read
// - bit 6 holds data toggle of last good packet
// - bit 0 set when the last data transfer completed well
// - bits 4..1 hold the error code, zero means no error
// - code 1 when pid check nibble is not the complement
// - code 2 when pid check is fine but pid is undefined
// - code 3 for wrong packet kind or setup to non-control endpoint
// - codes 4..8, 13, 14 for crc, timeout, babble, eop, stuffing, sync
// - code 9 when a nak was sent or received
// - code 10 when a stall answered a token to a stalled endpoint
// - code 11 when a packet overflows the free buffer space
// - code 12 when an isochronous endpoint sent an empty packet
// - code 15 on wrong toggle, and that packet's data is discarded
// - suspend blocks all writes, the unlock key unlocks only after resume, block kept until unlocked
// - register reads return zero after a suspend until the unlock command
// - unlock key travels low byte first, then high byte
// - 16-bit scratch word, written by one code, read by another
// - only scratch bits 12..0 hold data, upper bits written zero
// - frame command returns frame number of last good sof
// - frame number cleared to zero on bus reset until next sof
// - identity returns part code high byte, bcd revision low byte
module pgc_general_commands
  import pgc_pkg::*;
#(
  parameter logic [7:0] PART_CODE   = 8'h5A,  // arbitrary value
  parameter logic [7:0] SILICON_REV = 8'h12   // arbitrary value
) (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  // processor command/data port
  input  wire logic                 cmdWrite,
  input  wire logic                 dataWrite,
  input  wire logic                 dataRead,
  input  wire logic [BYTE_W-1:0]    busIn,
  output      logic [BYTE_W-1:0]    dataOut,
  output      logic                 dataOutValid,
  // bus state
  input  wire logic                 suspended,
  input  wire logic                 busReset,
  input  wire logic                 sofValid,
  input  wire logic [FRAME_W-1:0]   sofFrame,
  // transaction report from serial engine
  input  wire logic                 txnDone,
  input  wire logic [EP_W-1:0]      txnEndpoint,
  input  wire logic [BYTE_W-1:0]    txnPid,
  input  wire logic                 txnDataXfer,
  input  wire logic                 txnToggle,
  input  wire logic [FAULT_W-1:0]   txnFault,
  // effects on the rest of the controller
  output      logic                 writeAllowed,
  output      logic                 dataDiscard
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    pgc_cmd_type                    cmd;
    logic [EP_W-1:0]                epSel;
    logic                           byteHi;
    logic [BYTE_W-1:0]              lowByte;
    logic [EP_COUNT-1:0][BYTE_W-1:0] status;
    logic [EP_COUNT-1:0]            pending;
    logic                           locked;
    logic [SCRATCH_W-1:0]           scratch;
    logic [FRAME_W-1:0]             frame;
    logic [BYTE_W-1:0]              dataOut;
    logic                           dataOutValid;
    logic                           writeAllowed;
    logic                           discard;
  } pgc_state_type;

  pgc_state_type s_reg;
  pgc_state_type s_next;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic pidCheckBad(input logic [BYTE_W-1:0] pid);
    return pid[2*PID_NIB-1:PID_NIB] != ~pid[PID_NIB-1:0];
  endfunction : pidCheckBad

  function automatic logic pidDefined(input logic [PID_NIB-1:0] nib);
    return nib inside {PID_OUT, PID_IN, PID_SOF, PID_SETUP, PID_DATA0,
                       PID_DATA1, PID_ACK, PID_NAK, PID_STALL, PID_PRE};
  endfunction : pidDefined

  // line faults mask everything after them, stall, nak and iso empty last
  function automatic logic [3:0] encodeError(
    input logic [BYTE_W-1:0]  pid,
    input logic [EP_W-1:0]    ep,
    input logic [FAULT_W-1:0] f
  );
    logic [3:0] code;
    code = ERR_NONE;
    if (pidCheckBad(pid)) begin
      code = ERR_PID_CHECK;
    end else if (!pidDefined(pid[PID_NIB-1:0])) begin
      code = ERR_PID_UNDEF;
    end else if (f[FLT_STUFF]) begin
      code = ERR_STUFF;
    end else if (f[FLT_SYNC]) begin
      code = ERR_SYNC;
    end else if (f[FLT_EOP]) begin
      code = ERR_EOP;
    end else if (f[FLT_TOKEN_CRC]) begin
      code = ERR_TOKEN_CRC;
    end else if (f[FLT_DATA_CRC]) begin
      code = ERR_DATA_CRC;
    end else if (f[FLT_BABBLE]) begin
      code = ERR_BABBLE;
    end else if (f[FLT_TIMEOUT]) begin
      code = ERR_TIMEOUT;
    end else if (f[FLT_UNEXPECT] ||
                 (pid[PID_NIB-1:0] == PID_SETUP && ep > EP_CTRL_LAST)) begin
      code = ERR_UNEXPECT;
    end else if (f[FLT_TOGGLE]) begin
      code = ERR_TOGGLE;
    end else if (f[FLT_OVERFLOW]) begin
      code = ERR_OVERFLOW;
    end else if (f[FLT_STALL]) begin
      code = ERR_STALL;
    end else if (f[FLT_NAK]) begin
      code = ERR_NAK;
    end else if (f[FLT_ISO_EMPTY]) begin
      code = ERR_ISO_EMPTY;
    end
    return code;
  endfunction : encodeError

  // two-byte registers go out low byte first
  function automatic logic [BYTE_W-1:0] byteOf(
    input logic [WORD_W-1:0] word,
    input logic              hi
  );
    return hi ? word[WORD_W-1:BYTE_W] : word[BYTE_W-1:0];
  endfunction : byteOf

  function automatic pgc_cmd_type decodeCmd(input logic [BYTE_W-1:0] code);
    pgc_cmd_type c;
    c = PGC_IDLE;
    if (code >= CMD_STATUS_LO && code <= CMD_STATUS_HI) begin
      c = PGC_STATUS;
    end else if (code == CMD_UNLOCK) begin
      c = PGC_UNLOCK;
    end else if (code == CMD_SCR_WR) begin
      c = PGC_SCR_WR;
    end else if (code == CMD_SCR_RD) begin
      c = PGC_SCR_RD;
    end else if (code == CMD_FRAME) begin
      c = PGC_FRAME;
    end else if (code == CMD_IDENT) begin
      c = PGC_IDENT;
    end
    return c;
  endfunction : decodeCmd

  // ----------------------------------------------------------------
  // transaction decode
  // ----------------------------------------------------------------
  logic [3:0]        errNow;
  logic              okNow;
  logic              readHit;
  logic [BYTE_W-1:0] statusSel;

  assign errNow    = encodeError(txnPid, txnEndpoint, txnFault);
  assign okNow     = txnDataXfer && (errNow == ERR_NONE);
  assign statusSel = s_reg.status[s_reg.epSel];
  assign readHit   = dataRead && !cmdWrite && !dataWrite && !s_reg.locked
                     && s_reg.cmd == PGC_STATUS && s_reg.epSel == txnEndpoint;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next              = s_reg;
    s_next.dataOutValid = 1'b0;
    s_next.discard      = 1'b0;

    // protection stays set across resume
    if (suspended) begin
      s_next.locked = 1'b1;
    end

    // command phase
    if (cmdWrite) begin
      s_next.cmd    = decodeCmd(busIn);
      s_next.epSel  = busIn[EP_W-1:0];
      s_next.byteHi = 1'b0;
    end else if (dataWrite) begin
      unique case (s_reg.cmd)
        PGC_UNLOCK: begin
          // key is accepted even while locked, it is the only way out
          if (!s_reg.byteHi) begin
            s_next.lowByte = busIn;
            s_next.byteHi  = 1'b1;
          end else begin
            s_next.byteHi = 1'b0;
            if ({busIn, s_reg.lowByte} == UNLOCK_KEY && !suspended) begin
              s_next.locked = 1'b0;
            end
          end
        end
        PGC_SCR_WR: begin
          if (!s_reg.byteHi) begin
            s_next.lowByte = busIn;
            s_next.byteHi  = 1'b1;
          end else begin
            s_next.byteHi = 1'b0;
            if (!s_reg.locked) begin
              // upper bits are not stored at all
              s_next.scratch = SCRATCH_W'({busIn, s_reg.lowByte});
            end
          end
        end
        default: begin
          s_next.byteHi = s_reg.byteHi;
        end
      endcase
    end else if (dataRead) begin
      s_next.dataOutValid = 1'b1;
      s_next.byteHi       = !s_reg.byteHi;
      s_next.dataOut      = '0;
      if (!s_reg.locked) begin
        unique case (s_reg.cmd)
          PGC_STATUS: begin
            s_next.dataOut                           = statusSel;
            s_next.status[s_reg.epSel][ST_STATUS_OVERRUN_FLAG]    = 1'b0;
            s_next.pending[s_reg.epSel]              = 1'b0;
            s_next.byteHi                            = 1'b0;
          end
          PGC_SCR_RD: begin
            s_next.dataOut = byteOf(WORD_W'(s_reg.scratch), s_reg.byteHi);
          end
          PGC_FRAME: begin
            s_next.dataOut = byteOf(WORD_W'(s_reg.frame), s_reg.byteHi);
          end
          PGC_IDENT: begin
            s_next.dataOut = byteOf({PART_CODE, SILICON_REV}, s_reg.byteHi);
          end
          default: begin
            s_next.dataOut = '0;
          end
        endcase
      end
    end

    // frame number; cleared on bus reset rather than left floating
    if (busReset) begin
      s_next.frame = '0;
    end
    if (sofValid) begin
      s_next.frame = sofFrame;
    end

    // transaction record wins over a same-cycle read clear
    if (txnDone) begin
      s_next.status[txnEndpoint][ST_STATUS_OVERRUN_FLAG] =
        s_reg.pending[txnEndpoint] && !readHit;
      s_next.status[txnEndpoint][ST_ERR_MSB:ST_ERR_LSB] = errNow;
      s_next.status[txnEndpoint][ST_OK]     = okNow;
      s_next.status[txnEndpoint][ST_STATUS_OVERRUN_FLAG-2] = 1'b0;
      if (okNow) begin
        s_next.status[txnEndpoint][ST_TOGGLE] = txnToggle;
      end
      s_next.pending[txnEndpoint] = 1'b1;
      s_next.discard = (errNow == ERR_TOGGLE);
    end

    s_next.writeAllowed = !s_next.locked;
  end

  // ----------------------------------------------------------------
  // registers and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg.cmd          <= PGC_IDLE;
      s_reg.epSel        <= '0;
      s_reg.byteHi       <= 1'b0;
      s_reg.lowByte      <= '0;
      s_reg.status       <= {EP_COUNT{STATUS_RESET}};
      s_reg.pending      <= '0;
      s_reg.locked       <= 1'b0;
      s_reg.scratch      <= '0;
      s_reg.frame        <= '0;
      s_reg.dataOut      <= '0;
      s_reg.dataOutValid <= 1'b0;
      s_reg.writeAllowed <= 1'b1;
      s_reg.discard      <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign dataOut      = s_reg.dataOut;
  assign dataOutValid = s_reg.dataOutValid;
  assign writeAllowed = s_reg.writeAllowed;
  assign dataDiscard  = s_reg.discard;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_STATUS_READ: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (dataRead && !cmdWrite && !dataWrite && !s_reg.locked && s_reg.cmd == PGC_STATUS)
    |=> (dataOutValid && dataOut == $past(statusSel)))
    else $error("status read returned wrong byte");

  AST_TXN_REPLACE: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    txnDone |=> (s_reg.status[$past(txnEndpoint)][ST_ERR_MSB:ST_ERR_LSB]
                 == $past(errNow)))
    else $error("transaction did not replace error field");

  AST_STATUS_OVERRUN_FLAG: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (txnDone && s_reg.pending[txnEndpoint] && !readHit)
    |=> s_reg.status[$past(txnEndpoint)][ST_STATUS_OVERRUN_FLAG])
    else $error("overrun flag not set");

  AST_TOGGLE: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (txnDone && okNow)
    |=> (s_reg.status[$past(txnEndpoint)][ST_TOGGLE] == $past(txnToggle)))
    else $error("toggle bit not recorded");

  AST_OK_BIT: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    txnDone |=> (s_reg.status[$past(txnEndpoint)][ST_OK] == $past(okNow)))
    else $error("transfer ok bit wrong");

  AST_PID_CHECK: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (txnDone && txnPid[2*PID_NIB-1:PID_NIB] != ~txnPid[PID_NIB-1:0])
    |=> (s_reg.status[$past(txnEndpoint)][ST_ERR_MSB:ST_ERR_LSB] == ERR_PID_CHECK))
    else $error("pid check error not coded");

  AST_DISCARD: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (txnDone && errNow == ERR_TOGGLE) |=> dataDiscard ##1 !dataDiscard)
    else $error("toggle error did not discard once");

  AST_LOCK: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    suspended |=> (s_reg.locked && !writeAllowed))
    else $error("suspend did not lock writes");

  AST_READ_BLOCKED: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (dataRead && !cmdWrite && !dataWrite && s_reg.locked) |=> (dataOutValid && dataOut == '0))
    else $error("read returned data while locked");

  AST_SCRATCH_HI: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (dataRead && !cmdWrite && !dataWrite && !s_reg.locked
     && s_reg.cmd == PGC_SCR_RD && s_reg.byteHi)
    |=> (dataOut[BYTE_W-1:SCRATCH_W-BYTE_W] == '0))
    else $error("scratch upper bits not zero");

  AST_FRAME: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    sofValid |=> (s_reg.frame == $past(sofFrame)))
    else $error("frame number not captured");

  AST_IDENT: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (dataRead && !cmdWrite && !dataWrite && !s_reg.locked
     && s_reg.cmd == PGC_IDENT && s_reg.byteHi)
    |=> (dataOut == PART_CODE))
    else $error("identity high byte wrong");

  AST_IDENT_REV: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (dataRead && !cmdWrite && !dataWrite && !s_reg.locked
     && s_reg.cmd == PGC_IDENT && !s_reg.byteHi)
    |=> (dataOut == SILICON_REV))
    else $error("identity revision byte wrong");

endmodule : pgc_general_commands

//--- testbench/pgc_cpu_model.sv
// processor model on the command/data port, notes expected read bytes
// assumes the bench pops expQ on every dataOutValid pulse
module pgc_cpu_model
  import pgc_pkg::*;
(
  // clock
  input  wire logic              ref_clk,
  // command/data port
  output      logic              cmdWrite,
  output      logic              dataWrite,
  output      logic              dataRead,
  output      logic [BYTE_W-1:0] busIn
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [BYTE_W-1:0] expQ[$];

  initial begin
    cmdWrite  = 1'b0;
    dataWrite = 1'b0;
    dataRead  = 1'b0;
    busIn     = 8'h00;
  end

  // one strobe: kind 0 command, 1 write, 2 read
  task automatic strobe(input int kind, input logic [BYTE_W-1:0] b);
    @(posedge ref_clk);
    cmdWrite  <= (kind == 0);
    dataWrite <= (kind == 1);
    dataRead  <= (kind == 2);
    busIn     <= b;
    @(posedge ref_clk);
    cmdWrite  <= 1'b0;
    dataWrite <= 1'b0;
    dataRead  <= 1'b0;
    busIn     <= ~b;  // released bus must not keep the old byte
  endtask : strobe

  task automatic cmd(input logic [BYTE_W-1:0] c);
    strobe(0, c);
  endtask : cmd

  task automatic wr(input logic [BYTE_W-1:0] b);
    strobe(1, b);
  endtask : wr

  task automatic rd(input logic [BYTE_W-1:0] e);
    expQ.push_back(e);
    strobe(2, busIn);
  endtask : rd

  task automatic wr16(input logic [WORD_W-1:0] w);
    wr(w[7:0]);
    wr(w[15:8]);
  endtask : wr16

  task automatic rd16(input logic [WORD_W-1:0] w);
    rd(w[7:0]);
    rd(w[15:8]);
  endtask : rd16
endmodule : pgc_cpu_model

//--- testbench/tb.sv
// self-checking bench of the general command interpreter
// assumes pgc_cpu_model drives the command port
`define CHK(what, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
  $display("Error %s expected %h seen %h", what, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pgc_pkg::*;
  localparam logic [7:0] PART  = 8'h4C;  // arbitrary value
  localparam logic [7:0] REV   = 8'h21;  // arbitrary value
  localparam int         LIMIT = 5000;

  logic                 ref_clk, rst_n, cmdWrite, dataWrite, dataRead, dataOutValid;
  logic                 suspended, busReset, sofValid, txnDone, txnDataXfer, txnToggle;
  logic                 writeAllowed, dataDiscard, t1, t2;
  logic [BYTE_W-1:0]    busIn, dataOut, txnPid, e, xb;
  logic [FRAME_W-1:0]   sofFrame, fr;
  logic [EP_W-1:0]      txnEndpoint, ep;
  logic [FAULT_W-1:0]   txnFault;
  logic [WORD_W-1:0]    w;
  int                   mismatches = 0;
  int                   tests_run = 0;
  int                   cycles = 0;
  int                   seed;

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  pgc_general_commands #(.PART_CODE(PART), .SILICON_REV(REV)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .cmdWrite(cmdWrite), .dataWrite(dataWrite),
    .dataRead(dataRead), .busIn(busIn), .dataOut(dataOut), .dataOutValid(dataOutValid),
    .suspended(suspended), .busReset(busReset), .sofValid(sofValid), .sofFrame(sofFrame),
    .txnDone(txnDone), .txnEndpoint(txnEndpoint), .txnPid(txnPid),
    .txnDataXfer(txnDataXfer), .txnToggle(txnToggle), .txnFault(txnFault),
    .writeAllowed(writeAllowed), .dataDiscard(dataDiscard));

  pgc_cpu_model cpu (.ref_clk(ref_clk), .cmdWrite(cmdWrite), .dataWrite(dataWrite),
    .dataRead(dataRead), .busIn(busIn));

  // ----------------------------------------
  // read monitor and watchdog
  // ----------------------------------------
  always @(negedge ref_clk) begin
    if (dataOutValid === 1'b1) begin
      if (cpu.expQ.size() == 0) begin
        `CHK("unexpected read", 1'b0, 1'b1)
      end else begin
        e = cpu.expQ.pop_front();
        `CHK("read byte", e, dataOut)
      end
    end
  end

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      mismatches++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize

  task automatic txn(input logic [3:0] p, input logic [7:0] pid, input logic tg,
                     input logic [FAULT_W-1:0] f);
    @(posedge ref_clk);
    txnDone     <= 1'b1;
    txnEndpoint <= p;
    txnPid      <= pid;
    txnToggle   <= tg;
    txnFault    <= f;
    @(posedge ref_clk);
    txnDone     <= 1'b0;
    txnPid      <= ~pid;
    txnFault    <= ~f;
    @(negedge ref_clk);
    `CHK("discard", f[FLT_TOGGLE], dataDiscard)
  endtask : txn

  // transaction, then status read noted with its expected byte
  task automatic chkTxn(input logic [3:0] p, input logic [7:0] pid, input logic tg,
                        input logic [FAULT_W-1:0] f, input logic [7:0] x);
    txn(p, pid, tg, f);
    cpu.cmd(CMD_STATUS_LO | {4'h0, p});
    cpu.rd(x);
  endtask : chkTxn

  initial begin
    seed = $urandom(32'hD145);
    rst_n = 1'b0;
    suspended = 1'b0;
    busReset = 1'b0;
    sofValid = 1'b0;
    sofFrame = '0;
    txnDone = 1'b0;
    txnEndpoint = '0;
    txnPid = '0;
    txnDataXfer = 1'b1;
    txnToggle = 1'b0;
    txnFault = '0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    cpu.cmd(CMD_IDENT);
    cpu.rd(REV);
    cpu.rd(PART);
    cpu.cmd(CMD_STATUS_HI);
    cpu.rd(STATUS_RESET);
    chkTxn(4'h0, 8'h00, 1'b0, '0, {3'b000, ERR_PID_CHECK, 1'b0});
    chkTxn(4'h1, 8'hF0, 1'b0, '0, {3'b000, ERR_PID_UNDEF, 1'b0});
    // fault bits map onto codes 3..15 in order
    for (int i = 0; i < FAULT_W; i++) begin
      xb = {3'b000, 4'(i + 3), 1'b0};
      chkTxn(4'(i + 2), 8'hC3, 1'b0, FAULT_W'(1) << i, xb);
    end
    // setup token is legal on the control endpoints only
    chkTxn(4'h2, 8'h2D, 1'b0, '0, {3'b000, ERR_UNEXPECT, 1'b0});
    chkTxn(4'h1, 8'h2D, 1'b0, '0, {3'b000, ERR_NONE, 1'b1});
    // no data stage: no ok bit, toggle bit left alone
    txnDataXfer <= 1'b0;
    chkTxn(4'h0, 8'hD2, 1'b1, '0, {3'b000, ERR_NONE, 1'b0});
    txnDataXfer <= 1'b1;
    // read and new event on one edge: the event wins, status_overrun_flag stays clear
    cpu.cmd(CMD_STATUS_LO | 8'h0E);
    fork
      txn(4'hE, 8'h4B, 1'b1, '0);
      cpu.rd({3'b000, ERR_TOGGLE, 1'b0});
    join
    cpu.rd({1'b0, 1'b1, 1'b0, ERR_NONE, 1'b1});
    repeat (8) begin
      ep = 4'($urandom_range(15));
      t1 = 1'($urandom);
      t2 = 1'($urandom);
      txn(ep, t1 ? 8'h4B : 8'hC3, t1, '0);
      xb = {1'b1, t2, 1'b0, ERR_NONE, 1'b1};
      chkTxn(ep, t2 ? 8'h4B : 8'hC3, t2, '0, xb);
      cpu.rd({1'b0, t2, 1'b0, ERR_NONE, 1'b1});
    end
    w = 16'($urandom_range(16'h1FFF));
    cpu.cmd(CMD_SCR_WR);
    cpu.wr16(w);
    cpu.cmd(CMD_SCR_RD);
    cpu.rd16(w);
    fr = 11'($urandom);
    @(posedge ref_clk) busReset <= 1'b1;
    @(posedge ref_clk) busReset <= 1'b0;
    @(posedge ref_clk) sofValid <= 1'b1;
    sofFrame <= fr;
    @(posedge ref_clk) sofValid <= 1'b0;
    sofFrame <= ~fr;
    cpu.cmd(CMD_FRAME);
    cpu.rd16({5'b00000, fr});
    @(posedge ref_clk) suspended <= 1'b1;
    cpu.cmd(CMD_SCR_WR);
    cpu.wr16(16'h0ABC);
    @(posedge ref_clk) suspended <= 1'b0;
    repeat (2) @(negedge ref_clk);
    `CHK("write allowed", 1'b0, writeAllowed)
    cpu.cmd(CMD_SCR_RD);
    cpu.rd16(16'h0000);
    // key bytes swapped must not unlock
    cpu.cmd(CMD_UNLOCK);
    cpu.wr16(16'h37AA);
    repeat (2) @(negedge ref_clk);
    `CHK("write allowed", 1'b0, writeAllowed)
    cpu.cmd(CMD_UNLOCK);
    cpu.wr16(UNLOCK_KEY);
    repeat (2) @(negedge ref_clk);
    `CHK("write allowed", 1'b1, writeAllowed)
    cpu.cmd(CMD_SCR_RD);
    cpu.rd16(w);
    repeat (4) @(negedge ref_clk);
    `CHK("pending reads", 0, cpu.expQ.size())
    summarize();
  end
endmodule : tb
